// >>> hw/guard_pkg.sv
// shared constants and types for the address map access guard
package guard_pkg;
    // region bounds
    localparam logic [31:0] code_lo = 32'h0000_0000;
    localparam logic [31:0] code_hi = 32'h1fff_ffff;
    localparam logic [31:0] dreg_lo = 32'h2000_0000;
    localparam logic [31:0] dreg_hi = 32'h3fff_ffff;
    localparam logic [31:0] peri_lo = 32'h4000_0000;
    localparam logic [31:0] peri_hi = 32'h5fff_ffff;
    localparam logic [31:0] xram_lo = 32'h6000_0000;
    localparam logic [31:0] xram_hi = 32'h9fff_ffff;
    localparam logic [31:0] ppb_lo = 32'he000_0000;
    localparam logic [31:0] ppb_hi = 32'he00f_ffff;
    localparam logic [31:0] vector_base = 32'h0000_0000;
    // boot rom, supervisory flash and the whole flash range inside the code region
    localparam logic [31:0] brom_lo = 32'h0000_0000;
    localparam logic [31:0] brom_hi = 32'h0000_ffff;
    localparam logic [31:0] sflash_lo = 32'h1600_0000;
    localparam logic [31:0] sflash_hi = 32'h1600_7fff;
    localparam logic [31:0] flash_lo = 32'h1000_0000;
    localparam logic [31:0] flash_hi = 32'h1600_7fff;
    // memory geometry
    localparam int flash_width_bits = 128;
    localparam int row_bytes = 512;
    localparam int cache_bytes = 8192;
    localparam int cache_ways = 4;
    localparam int fuse_bits = 1024;
    localparam int bank0_regions = 13;
    localparam int bank_count = 3;
    localparam int ctx_count = 8;
    localparam int guard_slots = 8;
    // contexts
    localparam logic [2:0] ctx_boot = 3'h0;
    localparam logic [2:0] ctx_user = 3'h6;
    // register offsets (byte addresses)
    localparam logic [7:0] reg_mode = 8'h00;
    localparam logic [7:0] reg_lifecycle = 8'h04;
    localparam logic [7:0] reg_bank0_pwr = 8'h08;
    localparam logic [7:0] reg_bank0_ret = 8'h0c;
    localparam logic [7:0] reg_bank12 = 8'h10;
    localparam logic [7:0] reg_fuse_addr = 8'h14;
    localparam logic [7:0] reg_fuse_prog = 8'h18;
    localparam logic [7:0] reg_fuse_data = 8'h1c;
    localparam logic [7:0] reg_status = 8'h20;
    localparam logic [7:0] reg_sysreq = 8'h24;
    localparam logic [7:0] reg_gslot_base = 8'h40;
    localparam logic [7:0] reg_gslot_end = 8'h60;
    // reset values
    localparam logic [12:0] bank0_pwr_rst = 13'h1fff;
    localparam logic [3:0] bank12_rst = 4'h3;
    localparam logic [31:0] slot_rst = 32'h0000_00ff;
    // bus-master identities
    typedef enum logic [1:0] {
        mst_main, mst_secondary, mst_dma, mst_debug
    } master_e;
    // target selection
    typedef enum logic [2:0] {
        tgt_none, tgt_code, tgt_peri, tgt_xram, tgt_ppb
    } target_e;
    // one access as presented by a master
    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic priv;
        logic secure;
        logic [2:0] ctx;
        master_e master;
        logic [31:0] addr;
    } access_s;
    // verdict on one access
    typedef struct packed {
        logic valid;
        logic error;
        target_e target;
        logic flash_sel;
        logic row_start;
    } verdict_s;
endpackage

// >>> hw/address_map_access_guard.sv
// address decode and access checks for the shared dual-processor address space
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
module address_map_access_guard #(
    parameter int fuse_count = 1024,
    parameter int slots = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    // access under check
    input wire guard_pkg::access_s acc_in,
    output guard_pkg::verdict_s verdict,
    output logic [guard_pkg::flash_width_bits-1:0] flash_rd_mask,
    output logic [1:0] cache_sel,
    output logic sys_nmi,
    // system request strobes: main, debug
    input wire logic sysreq_main,
    input wire logic sysreq_debug,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire guard_pkg::access_s avs_who,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // power control
    output logic [12:0] bank0_pwr,
    output logic [12:0] bank0_ret,
    output logic [3:0] bank12_ctl
);
    import guard_pkg::*;

    initial begin
        if (fuse_count != fuse_bits || slots != guard_slots || fuse_count % 32 != 0) begin
            $error("unsupported guard geometry");
        end
    end

    // all module state
    typedef struct packed {
        verdict_s verdict;
        logic [flash_width_bits-1:0] rd_mask;
        logic [1:0] cache_sel;
        logic nmi;
        logic [31:0] rdata;
        logic wait_n;
        logic [1:0] resp;
        logic ultra_low_power_mode;
        logic secure_lc;
        logic [12:0] b0_pwr;
        logic [12:0] b0_ret;
        logic [3:0] b12;
        logic [4:0] fuse_addr;
        logic [fuse_count-1:0] fuse;
        logic [slots-1:0][31:0] slot;
    } state_s;

    state_s st_ff;
    state_s nxt_st;
    // decoded helpers
    target_e tgt;
    logic in_brom;
    logic in_sflash;
    logic in_flash;
    logic deny;
    logic [2:0] slot_idx;
    logic slot_hit;
    logic reg_ok;
    logic [31:0] rd;
    logic [4:0] fw;

    // region decode of the access under check
    always_comb begin
        tgt = tgt_none;
        if (acc_in.addr <= code_hi) begin
            tgt = tgt_code;
        end else if (acc_in.addr >= dreg_lo && acc_in.addr <= dreg_hi) begin
            tgt = tgt_none;
        end else if (acc_in.addr >= peri_lo && acc_in.addr <= peri_hi) begin
            tgt = tgt_peri;
        end else if (acc_in.addr >= xram_lo && acc_in.addr <= xram_hi) begin
            tgt = tgt_xram;
        end else if (acc_in.addr >= ppb_lo && acc_in.addr <= ppb_hi) begin
            tgt = tgt_ppb;
        end
        in_brom = (acc_in.addr >= brom_lo) && (acc_in.addr <= brom_hi);
        in_sflash = (acc_in.addr >= sflash_lo) && (acc_in.addr <= sflash_hi);
        in_flash = (acc_in.addr >= flash_lo) && (acc_in.addr <= flash_hi);
    end

    // protection checks; slot word: [7:0] context allow, [8] write,
    // [9] fetch, [10] user allowed, [11] non-secure allowed, [15:12] region (addr[31:28])
    always_comb begin
        deny = 1'b0;
        slot_hit = 1'b0;
        for (int i = 0; i < slots; i++) begin
            if (st_ff.slot[i][15:12] == acc_in.addr[31:28]) begin
                slot_hit = 1'b1;
                if (!st_ff.slot[i][acc_in.ctx]) deny = 1'b1;
                if (acc_in.write && !st_ff.slot[i][8]) deny = 1'b1;
                if (acc_in.fetch && !st_ff.slot[i][9]) deny = 1'b1;
                if (!acc_in.priv && !st_ff.slot[i][10]) deny = 1'b1;
                if (!acc_in.secure && !st_ff.slot[i][11]) deny = 1'b1;
            end
        end
        // unpopulated target
        if (tgt == tgt_none) deny = 1'b1;
        // no code from peripheral or core register space
        if (acc_in.fetch && !(tgt == tgt_code || tgt == tgt_xram)) deny = 1'b1;
        // boot rom fetch is secondary-only in boot context; boot rom writes always refused
        if (tgt == tgt_code && in_brom && acc_in.fetch &&
            !(acc_in.master == mst_secondary && acc_in.ctx == ctx_boot)) begin
            deny = 1'b1;
        end
        if (tgt == tgt_code && in_brom && acc_in.write) deny = 1'b1;
        // no flash writes in ultra-low-power mode
        if (in_flash && acc_in.write && st_ff.ultra_low_power_mode) deny = 1'b1;
        // supervisory sector frozen once secure
        if (in_sflash && acc_in.write && st_ff.secure_lc) deny = 1'b1;
    end

    // register read mux
    always_comb begin
        rd = 32'h0000_0000;
        reg_ok = 1'b1;
        slot_idx = avs_address[4:2];
        fw = st_ff.fuse_addr;
        if (avs_address == reg_mode) begin
            rd = {31'h0, st_ff.ultra_low_power_mode};
        end else if (avs_address == reg_lifecycle) begin
            rd = {31'h0, st_ff.secure_lc};
        end else if (avs_address == reg_bank0_pwr) begin
            rd = {19'h0, st_ff.b0_pwr};
        end else if (avs_address == reg_bank0_ret) begin
            rd = {19'h0, st_ff.b0_ret};
        end else if (avs_address == reg_bank12) begin
            rd = {28'h0, st_ff.b12};
        end else if (avs_address == reg_fuse_addr) begin
            rd = {27'h0, st_ff.fuse_addr};
        end else if (avs_address == reg_fuse_prog) begin
            rd = 32'h0000_0000;
        end else if (avs_address == reg_fuse_data) begin
            rd = st_ff.fuse[fw*32 +: 32];
        end else if (avs_address == reg_status) begin
            rd = {29'h0, st_ff.nmi, st_ff.secure_lc, st_ff.ultra_low_power_mode};
        end else if (avs_address == reg_sysreq) begin
            rd = 32'h0000_0000;
        end else if (avs_address >= reg_gslot_base && avs_address < reg_gslot_end) begin
            rd = st_ff.slot[slot_idx];
        end else begin
            reg_ok = 1'b0; // unmapped
        end
    end

    // next state
    always_comb begin
        nxt_st = st_ff;
        // verdict registered one cycle after the access
        nxt_st.verdict.valid = acc_in.valid;
        nxt_st.verdict.error = acc_in.valid && deny;
        nxt_st.verdict.target = deny ? tgt_none : tgt;
        nxt_st.verdict.flash_sel = acc_in.valid && !deny && in_flash;
        // a programming write must begin on a 512-byte row boundary
        nxt_st.verdict.row_start = acc_in.valid && !deny && in_flash && acc_in.write &&
            (acc_in.addr[8:0] == 9'h000);
        // whole 128-bit line fetched per flash read
        nxt_st.rd_mask = (acc_in.valid && in_flash && !acc_in.write) ?
            {flash_width_bits{1'b1}} : '0;
        // per-processor cache routing, other masters bypass
        nxt_st.cache_sel = 2'b00;
        if (acc_in.valid && in_flash && !acc_in.write) begin
            if (acc_in.master == mst_main) nxt_st.cache_sel = 2'b01;
            if (acc_in.master == mst_secondary) nxt_st.cache_sel = 2'b10;
        end
        // system request causes the secondary nmi; held until acknowledged
        if (sysreq_main || sysreq_debug) nxt_st.nmi = 1'b1;
        // bus slave: one wait cycle, answer on the second
        nxt_st.wait_n = 1'b0;
        nxt_st.resp = 2'b00;
        if ((avs_read || avs_write) && !st_ff.wait_n) begin
            nxt_st.wait_n = 1'b1;
            nxt_st.rdata = avs_read ? rd : 32'h0000_0000;
            nxt_st.resp = reg_ok ? 2'b00 : 2'b10;
            if (avs_write && reg_ok) begin
                if (avs_address == reg_mode) begin
                    nxt_st.ultra_low_power_mode = avs_writedata[0];
                end else if (avs_address == reg_lifecycle) begin
                    // lifecycle only advances
                    nxt_st.secure_lc = st_ff.secure_lc | avs_writedata[0];
                end else if (avs_address == reg_bank0_pwr) begin
                    nxt_st.b0_pwr = avs_writedata[12:0];
                end else if (avs_address == reg_bank0_ret) begin
                    nxt_st.b0_ret = avs_writedata[12:0];
                end else if (avs_address == reg_bank12) begin
                    nxt_st.b12 = avs_writedata[3:0];
                end else if (avs_address == reg_fuse_addr) begin
                    nxt_st.fuse_addr = avs_writedata[4:0];
                end else if (avs_address == reg_fuse_prog) begin
                    // or-in only; a blown bit never clears
                    nxt_st.fuse[fw*32 +: 32] = st_ff.fuse[fw*32 +: 32] | avs_writedata;
                end else if (avs_address == reg_status) begin
                    // acknowledge clears nmi unless a new request arrives
                    if (avs_writedata[2] && !(sysreq_main || sysreq_debug)) nxt_st.nmi = 1'b0;
                end else if (avs_address == reg_sysreq) begin
                    if (avs_writedata[0]) nxt_st.nmi = 1'b1;
                end else if (avs_address >= reg_gslot_base) begin
                    // user context may not reconfigure the guards
                    // context six is where user code on the main processor runs
                    if (avs_who.ctx == ctx_user) begin
                        nxt_st.resp = 2'b10;
                    end else begin
                        nxt_st.slot[slot_idx] = avs_writedata;
                    end
                end
            end
        end
    end

    // state register; guards preset at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.b0_pwr <= bank0_pwr_rst;
            st_ff.b12 <= bank12_rst;
            for (int i = 0; i < slots; i++) begin
                st_ff.slot[i] <= slot_rst;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from state, except avs_waitrequest, which is also gated by avs_read or avs_write
    assign verdict = st_ff.verdict;
    assign flash_rd_mask = st_ff.rd_mask;
    assign cache_sel = st_ff.cache_sel;
    assign sys_nmi = st_ff.nmi;
    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = !st_ff.wait_n && (avs_read || avs_write);
    assign avs_response = st_ff.resp;
    assign bank0_pwr = st_ff.b0_pwr;
    assign bank0_ret = st_ff.b0_ret;
    assign bank12_ctl = st_ff.b12;
endmodule

// >>> verif/address_map_access_guard_checker.sv
// assertions on access verdicts, system requests and register bus timing
`timescale 1ns/1ps
module guard_checker
    import guard_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire guard_pkg::access_s acc_in,
    input wire guard_pkg::verdict_s verdict,
    input wire logic [guard_pkg::flash_width_bits-1:0] flash_rd_mask,
    input wire logic sys_nmi,
    input wire logic sysreq_main,
    input wire logic sysreq_debug,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    // valid access whose address falls inside lo..hi
    function automatic logic hit(input logic [31:0] lo, input logic [31:0] hi);
        return acc_in.valid && acc_in.addr >= lo && acc_in.addr <= hi;
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // refused verdict: error and no target
    sequence s_refused;
        verdict.error && verdict.target == tgt_none;
    endsequence
    // request held while the slave still waits
    sequence s_bus_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    property p_code;
        hit(code_lo, code_hi) |=> verdict.error || verdict.target == tgt_code;
    endproperty
    a_code: assert property (p_code)
        else $error("code access misrouted");
    property p_dreg;
        hit(dreg_lo, dreg_hi) |=> s_refused;
    endproperty
    a_dreg: assert property (p_dreg)
        else $error("empty data window answered");
    property p_peri_fetch;
        hit(peri_lo, peri_hi) && acc_in.fetch |=> s_refused;
    endproperty
    a_peri_fetch: assert property (p_peri_fetch)
        else $error("fetch from peripheral space passed");
    property p_xram;
        hit(xram_lo, xram_hi) |=> verdict.error || verdict.target == tgt_xram;
    endproperty
    a_xram: assert property (p_xram)
        else $error("external ram misrouted");
    property p_ppb;
        hit(ppb_lo, ppb_hi) |=> verdict.error || verdict.target == tgt_ppb;
    endproperty
    a_ppb: assert property (p_ppb)
        else $error("core register range misrouted");
    property p_valid;
        acc_in.valid |=> verdict.valid;
    endproperty
    a_valid: assert property (p_valid)
        else $error("access got no verdict");
    property p_flash_rd;
        hit(flash_lo, flash_hi) && !acc_in.write |=> verdict.error || (&flash_rd_mask);
    endproperty
    a_flash_rd: assert property (p_flash_rd)
        else $error("flash read not full width");
    property p_brom;
        hit(brom_lo, brom_hi) && acc_in.fetch
            && !(acc_in.master == mst_secondary && acc_in.ctx == ctx_boot) |=> s_refused;
    endproperty
    a_brom: assert property (p_brom)
        else $error("boot rom fetch let through");
    property p_nmi;
        sysreq_main || sysreq_debug |=> sys_nmi;
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("system request raised no nmi");
    property p_hole;
        hit(32'ha000_0000, 32'hdfff_ffff) |=> s_refused;
    endproperty
    a_hole: assert property (p_hole)
        else $error("unused region answered");
    // an allowed flash write on a row boundary is flagged as a row start
    property p_row;
        hit(flash_lo, flash_hi) && acc_in.write && acc_in.addr[8:0] == 9'h000
            |=> verdict.error || verdict.row_start;
    endproperty
    a_row: assert property (p_row)
        else $error("row start not flagged");
    // one wait cycle, then the answer
    property p_bus;
        s_bus_wait |=> !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus answer late");
endmodule
bind address_map_access_guard guard_checker u_chk (.clk(clk), .rst_n(rst_n),
    .acc_in(acc_in), .verdict(verdict), .flash_rd_mask(flash_rd_mask), .sys_nmi(sys_nmi),
    .sysreq_main(sysreq_main), .sysreq_debug(sysreq_debug), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// >>> verif/access_master_model.sv
// bus master stand-in: presents one access and catches its verdict
`timescale 1ns/1ps
module access_master_model
    import guard_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire guard_pkg::access_s req,
    input wire logic go,
    input wire guard_pkg::verdict_s verdict,
    output guard_pkg::access_s acc,
    output guard_pkg::verdict_s seen,
    output logic done
);
    logic pend_ff; // verdict due at the next edge
    // one cycle of access, then an idle, cleared bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= '0;
            pend_ff <= 1'b0;
            done <= 1'b0;
            seen <= '0;
        end else begin
            acc <= go ? req : '0;
            pend_ff <= acc.valid;
            done <= pend_ff;
            // capture only in the verdict's own cycle
            if (pend_ff) begin
                seen <= verdict;
            end
        end
    end
endmodule

// >>> verif/tb_address_map_access_guard.sv
// self-checking bench for the address map access guard
`timescale 1ns/1ps
module tb_address_map_access_guard;
    import guard_pkg::*;
    logic clk = 1'b0; // 40 MHz
    logic rst_n = 1'b0;
    access_s acc_in;
    access_s req = '0;
    access_s avs_who = '0;
    verdict_s verdict, seen;
    logic go = 1'b0;
    logic done, sys_nmi, avs_waitrequest;
    logic sysreq_main = 1'b0;
    logic sysreq_debug = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [1:0] avs_response;
    logic [12:0] bank0_pwr, bank0_ret;
    logic [3:0] bank12_ctl;
    int failures = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    address_map_access_guard DUT (.clk(clk), .rst_n(rst_n), .acc_in(acc_in),
        .verdict(verdict), .flash_rd_mask(), .cache_sel(), .sys_nmi(sys_nmi),
        .sysreq_main(sysreq_main), .sysreq_debug(sysreq_debug), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_who(avs_who), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .bank0_pwr(bank0_pwr), .bank0_ret(bank0_ret),
        .bank12_ctl(bank12_ctl));
    access_master_model u_mst (.clk(clk), .rst_n(rst_n), .req(req), .go(go),
        .verdict(verdict), .acc(acc_in), .seen(seen), .done(done));
    // single exit of the run
    task automatic give_verdict();
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // four-state compare, reported at once
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // bounded wait ran out: count it and close
    task automatic hang(input string what);
        failures++;
        $display("[FAIL] %0t %s hung", $time, what);
        give_verdict();
    endtask
    // avalon cycle; on a read d is the expected data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [2:0] c, input logic [1:0] er);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        avs_who <= '{valid:1'b1, write:wr, fetch:1'b0, priv:1'b1, secure:1'b1, ctx:c,
                     master:mst_main, addr:32'h0};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) hang("bus");
        cmp(avs_response, er, "response");
        // data only matters on a good read
        if (!wr && er == 2'b00) cmp(avs_readdata, d, "read data");
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // one access through the master model, verdict compared
    task automatic chk(input logic [31:0] a, input logic f, input logic w, input master_e m,
                       input logic [2:0] c, input logic e, input target_e t);
        int n;
        @(posedge clk);
        req <= '{valid:1'b1, write:w, fetch:f, priv:1'b1, secure:1'b1, ctx:c, master:m,
                 addr:a};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 20);
        if (n >= 20) hang("access");
        cmp(seen.error, e, "error flag");
        cmp(seen.target, t, "target");
    endtask
    // system request by main strobe, debug strobe, register write
    task automatic nmi_case(input int how);
        if (how == 2) begin
            bus(1'b1, reg_sysreq, 32'h1, ctx_boot, 2'b00);
        end else begin
            @(posedge clk);
            sysreq_main <= (how == 0);
            sysreq_debug <= (how == 1);
            @(posedge clk);
            sysreq_main <= 1'b0;
            sysreq_debug <= 1'b0;
        end
        @(posedge clk);
        cmp(sys_nmi, 32'h1, "nmi raised");
        bus(1'b1, reg_status, 32'h4, ctx_boot, 2'b00);
        @(posedge clk);
        cmp(sys_nmi, 32'h0, "nmi cleared");
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp(bank0_pwr, 32'h1fff, "bank0 power");
        cmp(bank12_ctl, 32'h3, "bank1-2 control");
        bus(1'b0, reg_bank0_pwr, 32'h1fff, ctx_boot, 2'b00);
        bus(1'b0, reg_gslot_base, 32'hff, ctx_boot, 2'b00);
        bus(1'b0, 8'h30, 32'h0, ctx_boot, 2'b10);
        bus(1'b1, reg_gslot_base, 32'hfff, ctx_user, 2'b10);
        bus(1'b0, reg_gslot_base, 32'hff, ctx_boot, 2'b00);
        // every preset slot covers region 0 and bars fetches, so boot opens them all
        for (int i = 0; i < guard_slots; i++) begin
            bus(1'b1, reg_gslot_base + 8'(4 * i), 32'hfff, ctx_boot, 2'b00);
        end
        chk(32'h2000_0000, 0, 0, mst_main, ctx_user, 1, tgt_none);
        chk(32'h4000_0000, 1, 0, mst_main, ctx_user, 1, tgt_none);
        chk(32'h4000_0000, 0, 0, mst_main, ctx_user, 0, tgt_peri);
        chk(32'h6000_0000, 1, 0, mst_main, ctx_user, 0, tgt_xram);
        chk(32'he000_0000, 0, 0, mst_main, ctx_user, 0, tgt_ppb);
        chk(32'h1000_0000, 1, 0, mst_main, ctx_user, 0, tgt_code);
        chk(32'h0000_0000, 1, 0, mst_secondary, ctx_boot, 0, tgt_code);
        chk(32'h0000_0000, 1, 0, mst_main, ctx_boot, 1, tgt_none);
        chk(32'h0000_fffc, 1, 0, mst_secondary, 3'h1, 1, tgt_none);
        chk(32'ha000_0000, 0, 0, mst_main, ctx_user, 1, tgt_none);
        chk(32'h1000_0200, 0, 1, mst_main, ctx_user, 0, tgt_code);
        bus(1'b1, reg_mode, 32'h1, ctx_boot, 2'b00);
        chk(32'h1000_0200, 0, 1, mst_main, ctx_user, 1, tgt_none);
        chk(32'h1000_0200, 0, 0, mst_main, ctx_user, 0, tgt_code);
        bus(1'b1, reg_mode, 32'h0, ctx_boot, 2'b00);
        for (int i = 0; i < 3; i++) nmi_case(i);
        chk(sflash_lo, 0, 1, mst_main, ctx_user, 0, tgt_code);
        bus(1'b1, reg_lifecycle, 32'h1, ctx_boot, 2'b00);
        bus(1'b1, reg_lifecycle, 32'h0, ctx_boot, 2'b00);
        bus(1'b0, reg_status, 32'h2, ctx_boot, 2'b00);
        chk(sflash_lo, 0, 1, mst_main, ctx_user, 1, tgt_none);
        // last fuse word: bits only ever gather
        bus(1'b1, reg_fuse_addr, 32'h1f, ctx_boot, 2'b00);
        bus(1'b1, reg_fuse_prog, 32'h5, ctx_boot, 2'b00);
        bus(1'b1, reg_fuse_prog, 32'h2, ctx_boot, 2'b00);
        bus(1'b0, reg_fuse_data, 32'h7, ctx_boot, 2'b00);
        bus(1'b1, reg_fuse_prog, 32'h0, ctx_boot, 2'b00);
        bus(1'b0, reg_fuse_data, 32'h7, ctx_boot, 2'b00);
        bus(1'b1, reg_bank0_pwr, 32'h1, ctx_boot, 2'b00);
        bus(1'b1, reg_bank0_ret, 32'h1000, ctx_boot, 2'b00);
        bus(1'b1, reg_bank12, 32'hc, ctx_boot, 2'b00);
        @(posedge clk);
        cmp(bank0_pwr, 32'h1, "bank0 power");
        cmp(bank0_ret, 32'h1000, "bank0 retention");
        cmp(bank12_ctl, 32'hc, "bank1-2 control");
        give_verdict();
    end
endmodule
